// ==== include/qbpc_pkg.sv ====
package qbpc_pkg;
    // Pad count and interrupt field width
    localparam int NUM_PADS = 6;
    localparam int BITS_PER_PAD = 4;
    localparam int IRQ_BITS = 24;
    // Register byte offsets
    localparam logic [7:0] OFF_CLOCK_CTRL = 8'h04;
    localparam logic [7:0] OFF_SELECT_CTRL = 8'h0c;
    localparam logic [7:0] OFF_DATA0_CTRL = 8'h14;
    localparam logic [7:0] OFF_DATA1_CTRL = 8'h1c;
    localparam logic [7:0] OFF_DATA2_CTRL = 8'h24;
    localparam logic [7:0] OFF_DATA3_CTRL = 8'h2c;
    localparam logic [7:0] OFF_RAW_IRQ = 8'h30;
    localparam logic [7:0] OFF_CPU0_ENABLE = 8'h34;
    localparam logic [7:0] OFF_CPU0_FORCE = 8'h38;
    localparam logic [7:0] OFF_CPU0_STATUS = 8'h3c;
    // Control field positions
    localparam int FUNC_LSB = 0;
    localparam int OUT_OVR_LSB = 8;
    localparam int OE_OVR_LSB = 12;
    localparam int IN_OVR_LSB = 16;
    localparam int IRQ_OVR_LSB = 28;
    // Detector bit positions within a pad nibble
    localparam int DET_LEVEL_LOW = 0;
    localparam int DET_LEVEL_HIGH = 1;
    localparam int DET_EDGE_LOW = 2;
    localparam int DET_EDGE_HIGH = 3;
    // Reset values
    localparam logic [4:0] FUNC_NONE = 5'h1f;
    localparam logic [1:0] OVR_RESET = 2'h0;
    localparam logic [23:0] IRQ_RESET = 24'h00_0000;
    // Writable mask of a control register
    localparam logic [31:0] CTRL_MASK = 32'h3003_331f;
    // Edge bits of the raw register
    localparam logic [23:0] EDGE_MASK = 24'hcc_cccc;
    // Override codes
    typedef enum logic [1:0] {
        QBPC_OVR_PASS = 2'b00,
        QBPC_OVR_INVERT = 2'b01,
        QBPC_OVR_LOW = 2'b10,
        QBPC_OVR_HIGH = 2'b11
    } qbpc_ovr_t;
endpackage

// ==== design/qbpc_top.sv ====
`timescale 1ns/10ps
// Contract
// - Interrupt override: pass, invert, low, high
// - Peripheral input override: pass, invert, low, high
// - Output enable override: pass, invert, off, on
// - Output value override: pass, invert, low, high
// - Five-bit function select resets to 31
// - Edge flags latch; write one clears
// - Level bits read-only, follow pad level after interrupt override
// - Four bits per pad, clock pad lowest
// - Processor-0 enable mask, resets zero
// - Processor-0 force register, resets zero
// - Status is raw AND enable OR force
module qbpc_top
    import qbpc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pad side, clock pad is bit 0
    input wire logic [5:0] pad_in_i,
    output logic [5:0] pad_out_o,
    output logic [5:0] pad_oe_o,
    // Selected peripheral side
    input wire logic [5:0] peri_out_i,
    input wire logic [5:0] peri_oe_i,
    output logic [5:0] peri_in_o,
    output logic [29:0] func_sel_o,
    // Processor-0 interrupt
    output logic cpu0_irq_o
);
    // All module state
    typedef struct packed {
        logic [5:0] sync1;
        logic [5:0] sync2;
        logic [5:0] sync3;
        logic [5:0] level;
        logic [5:0][31:0] ctrl;
        logic [23:0] edges;
        logic [23:0] enable;
        logic [23:0] force_bits;
        logic ack;
        logic [31:0] rdata;
        logic [5:0] pout;
        logic [5:0] poe;
        logic [5:0] pin;
        logic irq;
    } qbpc_state_t;

    qbpc_state_t cur;
    qbpc_state_t next_cur;

    // Control register reset value
    localparam logic [31:0] CTRL_RESET = {27'h000_0000, FUNC_NONE};

    // Apply a two-bit override to one signal
    function automatic logic apply_ovr(input logic [1:0] code,
                                       input logic value);
        logic result;
        result = value;
        unique case (qbpc_ovr_t'(code))
            QBPC_OVR_PASS: result = value;
            QBPC_OVR_INVERT: result = ~value;
            QBPC_OVR_LOW: result = 1'b0;
            QBPC_OVR_HIGH: result = 1'b1;
        endcase
        return result;
    endfunction

    // Byte-enable merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Combinational view of pad interrupts and status
    logic [23:0] raw_irq;
    logic [23:0] status;
    logic [5:0] pad_irq;
    logic bus_req;
    logic bus_write;
    logic [31:0] wmask;

    always_comb begin
        wmask = merge(32'h0000_0000, 32'hffff_ffff, wb_sel_i);
        bus_req = wb_cyc_i && wb_stb_i && !cur.ack;
        bus_write = bus_req && wb_we_i;
        raw_irq = cur.edges;
        for (int p = 0; p < NUM_PADS; p++) begin
            pad_irq[p] = apply_ovr(cur.ctrl[p][IRQ_OVR_LSB +: 2],
                                   cur.level[p]);
            raw_irq[p*BITS_PER_PAD + DET_LEVEL_LOW] = ~pad_irq[p];
            raw_irq[p*BITS_PER_PAD + DET_LEVEL_HIGH] = pad_irq[p];
        end
        status = (raw_irq & cur.enable) | cur.force_bits;
    end

    // Next-state logic
    always_comb begin
        next_cur = cur;
        // Pad synchroniser; change counts when stages two and three agree
        next_cur.sync1 = pad_in_i;
        next_cur.sync2 = cur.sync1;
        next_cur.sync3 = cur.sync2;
        for (int p = 0; p < NUM_PADS; p++) begin
            if (cur.sync2[p] == cur.sync3[p]) begin
                next_cur.level[p] = cur.sync3[p];
            end
        end
        for (int p = 0; p < NUM_PADS; p++) begin
            if (bus_write && wb_adr_i == OFF_RAW_IRQ) begin
                next_cur.edges = next_cur.edges & ~(wb_dat_i[23:0]
                    & wmask[23:0] & EDGE_MASK);
            end
        end
        for (int p = 0; p < NUM_PADS; p++) begin
            // Set wins over a same-cycle clear
            if (next_cur.level[p] != cur.level[p]) begin
                if (apply_ovr(cur.ctrl[p][IRQ_OVR_LSB +: 2],
                              next_cur.level[p])) begin
                    next_cur.edges[p*BITS_PER_PAD + DET_EDGE_HIGH] = 1'b1;
                end else begin
                    next_cur.edges[p*BITS_PER_PAD + DET_EDGE_LOW] = 1'b1;
                end
            end
        end
        // Bus write to a control, enable or force register
        if (bus_write) begin
            for (int p = 0; p < NUM_PADS; p++) begin
                if (wb_adr_i == OFF_CLOCK_CTRL + 8'(p * 8)) begin
                    next_cur.ctrl[p] = merge(cur.ctrl[p], wb_dat_i,
                                             wb_sel_i) & CTRL_MASK;
                end
            end
            if (wb_adr_i == OFF_CPU0_ENABLE) begin
                next_cur.enable = 24'(merge({8'h00, cur.enable},
                                            wb_dat_i, wb_sel_i));
            end
            if (wb_adr_i == OFF_CPU0_FORCE) begin
                next_cur.force_bits = 24'(merge({8'h00, cur.force_bits},
                                                wb_dat_i, wb_sel_i));
            end
        end
        // Read mux, unmapped reads return zero
        next_cur.rdata = 32'h0000_0000;
        if (bus_req && !wb_we_i) begin
            for (int p = 0; p < NUM_PADS; p++) begin
                if (wb_adr_i == OFF_CLOCK_CTRL + 8'(p * 8)) begin
                    next_cur.rdata = cur.ctrl[p];
                end
            end
            unique case (wb_adr_i)
                OFF_RAW_IRQ: next_cur.rdata = {8'h00, raw_irq};
                OFF_CPU0_ENABLE: next_cur.rdata = {8'h00, cur.enable};
                OFF_CPU0_FORCE: next_cur.rdata = {8'h00, cur.force_bits};
                OFF_CPU0_STATUS: next_cur.rdata = {8'h00, status};
                default: ;
            endcase
        end
        // One-cycle ack, every address answered
        next_cur.ack = bus_req;
        // Pad and peripheral paths
        for (int p = 0; p < NUM_PADS; p++) begin
            next_cur.pout[p] = apply_ovr(cur.ctrl[p][OUT_OVR_LSB +: 2],
                                         peri_out_i[p]);
            next_cur.poe[p] = apply_ovr(cur.ctrl[p][OE_OVR_LSB +: 2],
                                        peri_oe_i[p]);
            next_cur.pin[p] = apply_ovr(cur.ctrl[p][IN_OVR_LSB +: 2],
                                        cur.level[p]);
        end
        next_cur.irq = |status;
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cur <= '0;
            for (int p = 0; p < NUM_PADS; p++) begin
                cur.ctrl[p] <= CTRL_RESET;
            end
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs
    always_comb begin
        wb_dat_o = cur.rdata;
        wb_ack_o = cur.ack;
        pad_out_o = cur.pout;
        pad_oe_o = cur.poe;
        peri_in_o = cur.pin;
        cpu0_irq_o = cur.irq;
        for (int p = 0; p < NUM_PADS; p++) begin
            func_sel_o[p*5 +: 5] = cur.ctrl[p][FUNC_LSB +: 5];
        end
    end

    // Assertions
    property p_irq_ovr;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (cur.ctrl[0][IRQ_OVR_LSB +: 2] == 2'b11) |-> raw_irq[1];
    endproperty
    a_irq_ovr: assert property (p_irq_ovr)
        else $error("forced high interrupt not seen");

    property p_in_ovr;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (cur.ctrl[0][IN_OVR_LSB +: 2] == 2'b01) ##1
        ($stable(cur.ctrl[0]) && $stable(cur.level))
        |-> peri_in_o[0] == ~cur.level[0];
    endproperty
    a_in_ovr: assert property (p_in_ovr)
        else $error("input invert wrong");

    property p_oe_ovr;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (cur.ctrl[0][OE_OVR_LSB +: 2] == 2'b10) |=> !pad_oe_o[0];
    endproperty
    a_oe_ovr: assert property (p_oe_ovr)
        else $error("disabled output enable high");

    property p_out_pass;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (cur.ctrl[3][OUT_OVR_LSB +: 2] == 2'b00)
        |=> pad_out_o[3] == $past(peri_out_i[3]);
    endproperty
    a_out_pass: assert property (p_out_pass)
        else $error("output pass wrong");

    property p_func_reset;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(rst_b_i) |-> func_sel_o[4:0] == FUNC_NONE;
    endproperty
    a_func_reset: assert property (p_func_reset)
        else $error("function select reset wrong");

    property p_edge_sticky;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (cur.edges[3] && !(bus_write && wb_adr_i == OFF_RAW_IRQ))
        |=> cur.edges[3];
    endproperty
    a_edge_sticky: assert property (p_edge_sticky)
        else $error("edge flag lost without clear");

    // Rising select pad at pass override sets its flag
    property p_edge_set;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(cur.level[1]) && $past(cur.ctrl[1][IRQ_OVR_LSB +: 2]) == 2'b00
        |-> cur.edges[BITS_PER_PAD + DET_EDGE_HIGH];
    endproperty
    a_edge_set: assert property (p_edge_set)
        else $error("rising edge flag not set");

    property p_level;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        raw_irq[4] != raw_irq[5];
    endproperty
    a_level: assert property (p_level)
        else $error("level bits not complementary");

    property p_reserved;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        wb_ack_o && $past(wb_adr_i) == OFF_CPU0_STATUS
        |-> wb_dat_o[31:24] == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits nonzero");

    property p_status;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == OFF_CPU0_STATUS
        |-> wb_dat_o == {8'h00, $past(raw_irq) & $past(cur.enable)
                         | $past(cur.force_bits)};
    endproperty
    a_status: assert property (p_status)
        else $error("status mismatch");

    property p_force;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (cur.force_bits != 24'h00_0000) |=> cpu0_irq_o;
    endproperty
    a_force: assert property (p_force)
        else $error("force did not raise interrupt");

    property p_enable_zero;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (cur.enable == 24'h00_0000 && cur.force_bits == 24'h00_0000)
        |=> !cpu0_irq_o;
    endproperty
    a_enable_zero: assert property (p_enable_zero)
        else $error("interrupt with nothing enabled");

    property p_irq_line;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        cpu0_irq_o == ($past(status) != 24'h00_0000);
    endproperty
    a_irq_line: assert property (p_irq_line)
        else $error("interrupt line mismatch");

    property p_ack_one;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("ack longer than one cycle");

    // Cover main scenarios
    c_rise: cover property (@(posedge ref_clk_i) $rose(cur.edges[3]));
    c_irq: cover property (@(posedge ref_clk_i) $rose(cpu0_irq_o));
    c_clear: cover property (@(posedge ref_clk_i) $fell(cur.edges[2]));
    c_force: cover property (@(posedge ref_clk_i) |cur.force_bits);
    c_read: cover property (@(posedge ref_clk_i)
        wb_ack_o && !wb_we_i);
endmodule

// ==== verification/qbpc_pad_model.sv ====
`timescale 1ns/10ps
// Pad bank: block drives a pad when enabled, else outside level
module qbpc_pad_model (
    input wire logic [5:0] pad_out_i,
    input wire logic [5:0] pad_oe_i,
    input wire logic [5:0] ext_lvl_i,
    output logic [5:0] pad_lvl_o
);
    // Resolve each pad wire from both drivers
    always_comb begin
        for (int p = 0; p < 6; p++) begin
            pad_lvl_o[p] = pad_oe_i[p] ? pad_out_i[p] : ext_lvl_i[p];
        end
    end
endmodule

// ==== verification/tb_qspi_bank_pad_control_irq.sv ====
`timescale 1ns/10ps
module tb_qspi_bank_pad_control_irq;
    import qbpc_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    // Bus master state
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    // Pad and peripheral side
    logic [5:0] ext_lvl = 6'h00;
    logic [5:0] peri_out = 6'h00;
    logic [5:0] peri_oe = 6'h00;
    logic [5:0] pad_lvl;
    logic [5:0] pad_out;
    logic [5:0] pad_oe;
    logic [5:0] peri_in;
    logic [29:0] fsel;
    logic irq;
    logic [31:0] seed = 32'h0000_c8f9;
    int num_errors = 0;
    int n_compared = 0;
    logic [7:0] ctl_off [6] = '{OFF_CLOCK_CTRL, OFF_SELECT_CTRL,
        OFF_DATA0_CTRL, OFF_DATA1_CTRL, OFF_DATA2_CTRL, OFF_DATA3_CTRL};

    // 50 MHz clock
    always #10 ref_clk_i = ~ref_clk_i;

    qbpc_top dut_u (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pad_in_i(pad_lvl), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
        .peri_out_i(peri_out), .peri_oe_i(peri_oe), .peri_in_o(peri_in),
        .func_sel_o(fsel), .cpu0_irq_o(irq));

    qbpc_pad_model pad_u (.pad_out_i(pad_out), .pad_oe_i(pad_oe),
        .ext_lvl_i(ext_lvl), .pad_lvl_o(pad_lvl));

    // Override code applied to one bit
    function automatic logic ovr(input logic [1:0] c, input logic v);
        case (c)
            2'h0: ovr = v;
            2'h1: ovr = ~v;
            2'h2: ovr = 1'b0;
            default: ovr = 1'b1;
        endcase
    endfunction

    // Raw level bits for pads at pass override
    function automatic logic [31:0] lvl_bits(input logic [5:0] l);
        lvl_bits = 32'h0000_0000;
        for (int p = 0; p < 6; p++) begin
            lvl_bits[4*p +: 2] = {l[p], ~l[p]};
        end
    endfunction

    // Xorshift source with fixed start
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic close_out();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Classic single cycle, held until ack seen
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge ref_clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (ack !== 1'b1 && n < 16);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            num_errors++;
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, q);
        chk(q, e);
    endtask

    // Let pad synchronisers settle
    task automatic settle();
        repeat (8) @(posedge ref_clk_i);
    endtask

    initial begin
        logic [31:0] r;
        logic [31:0] q;
        logic [31:0] en;
        logic [31:0] fo;
        logic [31:0] ctl;
        logic [1:0] c;
        logic l0;
        repeat (8) @(posedge ref_clk_i);
        chk(32'(fsel), 32'h3fff_ffff);
        rst_b_i <= 1'b1;
        // Reset values and unmapped read
        for (int i = 0; i < 6; i++) begin
            rc(ctl_off[i], 32'h0000_001f);
        end
        rc(OFF_CPU0_ENABLE, 32'h0000_0000);
        rc(OFF_CPU0_FORCE, 32'h0000_0000);
        rc(OFF_RAW_IRQ, 32'h0011_1111);
        rc(8'h40, 32'h0000_0000);
        // Control offsets and function select of the other pads
        for (int i = 1; i < 6; i++) begin
            r = xs();
            wr(ctl_off[i], r);
            rc(ctl_off[i], r & CTRL_MASK);
            chk(32'(fsel[5*i +: 5]), 32'(r[4:0]));
            wr(ctl_off[i], 32'h0000_001f);
        end
        // Every override code on the clock pad
        for (int k = 0; k < 4; k++) begin
            c = 2'(k);
            r = xs();
            peri_out <= r[10:5];
            peri_oe <= r[16:11];
            ext_lvl <= r[22:17];
            ctl = {2'h0, c, 10'h000, c, 2'h0, c, 2'h0, c, 3'h0, r[4:0]};
            wr(OFF_CLOCK_CTRL, ctl);
            settle();
            rc(OFF_CLOCK_CTRL, ctl);
            chk(32'(fsel[4:0]), 32'(r[4:0]));
            chk(32'(pad_out[0]), 32'(ovr(c, r[5])));
            chk(32'(pad_oe[0]), 32'(ovr(c, r[11])));
            l0 = ovr(c, r[11]) ? ovr(c, r[5]) : r[17];
            chk(32'(peri_in[0]), 32'(ovr(c, l0)));
            wb(1'b0, OFF_RAW_IRQ, 32'h0000_0000, q);
            chk(32'(q[1:0]), 32'({ovr(c, l0), ~ovr(c, l0)}));
        end
        wr(OFF_CLOCK_CTRL, 32'h0000_001f);
        peri_oe <= 6'h00;
        ext_lvl <= 6'h00;
        settle();
        wr(OFF_RAW_IRQ, 32'h00ff_ffff);
        // Edge latch and clear on the select pad
        rc(OFF_RAW_IRQ, 32'h0011_1111);
        ext_lvl <= 6'h02;
        settle();
        rc(OFF_RAW_IRQ, 32'h0011_11a1);
        wr(OFF_RAW_IRQ, 32'h0000_00a0);
        rc(OFF_RAW_IRQ, 32'h0011_1121);
        ext_lvl <= 6'h00;
        settle();
        rc(OFF_RAW_IRQ, 32'h0011_1151);
        // Enable, force, status and line
        for (int k = 0; k < 6; k++) begin
            r = xs();
            ext_lvl <= r[5:0];
            settle();
            wr(OFF_RAW_IRQ, 32'h00ff_ffff);
            rc(OFF_RAW_IRQ, lvl_bits(r[5:0]));
            en = (k == 0) ? 32'h0000_0000 : xs();
            fo = (k == 0) ? 32'h0000_0000 : xs() & xs() & xs();
            wr(OFF_CPU0_ENABLE, en);
            wr(OFF_CPU0_FORCE, fo);
            wr(OFF_CPU0_STATUS, 32'hffff_ffff);
            rc(OFF_CPU0_ENABLE, en & 32'h00ff_ffff);
            rc(OFF_CPU0_FORCE, fo & 32'h00ff_ffff);
            q = ((lvl_bits(r[5:0]) & en) | fo) & 32'h00ff_ffff;
            rc(OFF_CPU0_STATUS, q);
            chk(32'(irq), 32'(|q));
        end
        close_out();
    end
endmodule
